// [logic/lcr_logic_cell.sv]
// Configurable logic cell with two look-up tables and dual-port RAM mode
`timescale 1ns/1ps
// What this block does
// - Each look-up table gives any function of its four inputs via 16 entries.
// - The combine table takes three inputs, the third always the direct pin.
// - Output X picks first table or combine, output Y second table or combine.
// - Two storage elements take a generator output or the bypass input.
// - Storage elements are flip-flops, optionally transparent latches.
// - With both latch options off, only two unregistered results leave; a third must be registered.
// - The cell has thirteen logic inputs and four logic outputs.
// - The cell covers one 5-input function or 4+4+3 unrelated functions.
// - Dual-port mode joins both tables into one 16x1 RAM, one write two reads.
// - A read and a write may occur at once at different addresses.
// - A read and a write may occur at once at the same address.
// - Dual-port writes are edge-triggered only.
// - The shared address reads and writes the first table.
// - The dual read address reads the second table, written at shared address.
// - Unspecified memory contents start at zero.
// - Memory contents are unaffected by the global reset.
module lcr_logic_cell
    import lcr_pkg::*;
#(
    parameter logic [15:0] FIRST_INIT = LCR_LUT_INIT,
    parameter logic [15:0] SECOND_INIT = LCR_LUT_INIT,
    parameter logic [7:0] COMB_TABLE = LCR_COMB_INIT
) (
    input wire logic CLK,
    input wire logic RESET,
    // Configuration
    input wire lcr_mode_t MODE,
    input wire logic SEL_ALT_A,
    input wire logic SEL_ALT_B,
    input wire logic SEL_X_COMB,
    input wire logic SEL_Y_COMB,
    input wire lcr_src_t SRC_UPPER,
    input wire lcr_src_t SRC_LOWER,
    input wire logic LATCH_UPPER,
    input wire logic LATCH_LOWER,
    input wire logic LUT_LOAD,
    // Thirteen cell inputs
    input wire logic [3:0] FIRST_LUT_INPUTS,
    input wire logic [3:0] SECOND_LUT_INPUTS,
    input wire logic COMBINE_DIRECT_IN,
    input wire logic COMBINE_ALT_IN_A,
    input wire logic COMBINE_ALT_IN_B,
    input wire logic BYPASS_IN,
    input wire logic WRITE_EN,
    // Four cell outputs
    output logic X,
    output logic Y,
    output logic XQ,
    output logic YQ
);
    // ********************
    // Look-up tables
    // ********************
    logic first_out;
    logic second_out;
    logic wr_en;
    logic [3:0] second_rd_addr;

    // In dual-port mode write enable writes both tables at shared address
    assign wr_en = (MODE == LCR_MODE_DUALRAM) ? WRITE_EN : LUT_LOAD;
    assign second_rd_addr = SECOND_LUT_INPUTS;

    lcr_lut_ram #(.INIT(FIRST_INIT)) u_first (
        .clk(CLK),
        .wr_en(wr_en),
        .wr_addr(FIRST_LUT_INPUTS),
        .wr_data(BYPASS_IN),
        .rd_addr(FIRST_LUT_INPUTS),
        .rd_data(first_out)
    );

    // In dual-port mode the second table writes at the shared address, reads at its own
    lcr_lut_ram #(.INIT(SECOND_INIT)) u_second (
        .clk(CLK),
        .wr_en(wr_en),
        .wr_addr((MODE == LCR_MODE_DUALRAM) ? FIRST_LUT_INPUTS
                                             : SECOND_LUT_INPUTS),
        .wr_data(BYPASS_IN),
        .rd_addr(second_rd_addr),
        .rd_data(second_out)
    );

    // ********************
    // Combining generator
    // ********************
    logic comb_a;
    logic comb_b;
    logic comb_out;

    assign comb_a = (SEL_ALT_A == LCR_SEL_PIN) ? COMBINE_ALT_IN_A
                                               : first_out;
    assign comb_b = (SEL_ALT_B == LCR_SEL_PIN) ? COMBINE_ALT_IN_B
                                               : second_out;
    assign comb_out = COMB_TABLE[{COMBINE_DIRECT_IN, comb_b, comb_a}];

    // ********************
    // Combinational outputs
    // ********************
    assign X = SEL_X_COMB ? comb_out : first_out;
    assign Y = SEL_Y_COMB ? comb_out : second_out;

    // ********************
    // Storage elements
    // ********************
    function automatic logic pick_src(input lcr_src_t s, input logic f,
                                      input logic g, input logic h,
                                      input logic d);
        case (s)
            LCR_SRC_FIRST: pick_src = f;
            LCR_SRC_SECOND: pick_src = g;
            LCR_SRC_COMB: pick_src = h;
            default: pick_src = d;
        endcase
    endfunction : pick_src

    logic next_upper;
    logic next_lower;
    logic upper_q;
    logic lower_q;

    assign next_upper = pick_src(SRC_UPPER, first_out, second_out, comb_out,
                                 BYPASS_IN);
    assign next_lower = pick_src(SRC_LOWER, first_out, second_out, comb_out,
                                 BYPASS_IN);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            upper_q <= LCR_STORE_RESET;
        end else begin
            upper_q <= next_upper;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            lower_q <= LCR_STORE_RESET;
        end else begin
            lower_q <= next_lower;
        end
    end

    // Latch option: transparent path while latch mode selected
    assign XQ = LATCH_UPPER ? next_upper : upper_q;
    assign YQ = LATCH_LOWER ? next_lower : lower_q;

    // ********************
    // Checks
    // ********************
    a_ram_write_both: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == LCR_MODE_DUALRAM && WRITE_EN && $stable(MODE))
        ##1 (second_rd_addr == $past(FIRST_LUT_INPUTS) && !WRITE_EN)
        |-> second_out == $past(BYPASS_IN))
        else $error("dual port write not seen on second table");
    a_ram_same_read: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == LCR_MODE_DUALRAM && second_rd_addr == FIRST_LUT_INPUTS)
        |-> first_out == second_out)
        else $error("ports disagree at same address");
    a_ram_hold_no_we: assert property (@(posedge CLK) disable iff (RESET)
        (MODE == LCR_MODE_DUALRAM && !WRITE_EN && $stable(FIRST_LUT_INPUTS))
        ##1 $stable(FIRST_LUT_INPUTS) |-> $stable(first_out))
        else $error("table changed without write enable");
    a_x_select: assert property (@(posedge CLK)
        X == (SEL_X_COMB ? comb_out : first_out))
        else $error("X output select wrong");
    a_y_select: assert property (@(posedge CLK)
        Y == (SEL_Y_COMB ? comb_out : second_out))
        else $error("Y output select wrong");
    a_upper_capture: assert property (@(posedge CLK) disable iff (RESET)
        (!RESET && !LATCH_UPPER) ##1 !LATCH_UPPER
        |-> XQ == $past(next_upper))
        else $error("upper element missed capture");
    a_lower_capture: assert property (@(posedge CLK) disable iff (RESET)
        (!RESET && !LATCH_LOWER) ##1 !LATCH_LOWER
        |-> YQ == $past(next_lower))
        else $error("lower element missed capture");
    a_reset_clears: assert property (@(posedge CLK)
        RESET ##1 (!LATCH_UPPER && !LATCH_LOWER)
        |-> (XQ == LCR_STORE_RESET && YQ == LCR_STORE_RESET))
        else $error("storage not cleared by reset");
    a_comb_direct: assert property (@(posedge CLK)
        comb_out == COMB_TABLE[{COMBINE_DIRECT_IN, comb_b, comb_a}])
        else $error("combining table lookup wrong");
    a_latch_upper_pass: assert property (@(posedge CLK)
        LATCH_UPPER |-> XQ == next_upper)
        else $error("upper latch not transparent");
    a_latch_lower_pass: assert property (@(posedge CLK)
        LATCH_LOWER |-> YQ == next_lower)
        else $error("lower latch not transparent");
endmodule : lcr_logic_cell

// [logic/lcr_lut_ram.sv]
// One 16x1 look-up table usable as a write-once-per-edge RAM
`timescale 1ns/1ps
module lcr_lut_ram
    import lcr_pkg::*;
#(
    parameter int AW = LCR_LUT_INPUTS,
    parameter logic [(1<<AW)-1:0] INIT = LCR_LUT_INIT
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic rd_data
);
    // ********************
    // Table storage
    // ********************
    logic [(1<<AW)-1:0] table_bits = INIT;

    // Not touched by RESET: contents only change on writes
    always_ff @(posedge clk) begin
        if (wr_en) begin
            table_bits[wr_addr] <= wr_data;
        end
    end

    // Asynchronous read
    assign rd_data = table_bits[rd_addr];
endmodule : lcr_lut_ram

// [pkg/lcr_pkg.sv]
// Constants and types shared by the logic cell design
package lcr_pkg;
    // Table sizes
    localparam int LCR_LUT_INPUTS = 4;
    localparam int LCR_LUT_WORDS = 16;
    localparam int LCR_COMB_INPUTS = 3;
    localparam int LCR_COMB_WORDS = 8;
    // Default table contents after configuration (all zero)
    localparam logic [15:0] LCR_LUT_INIT = 16'h0000;
    localparam logic [7:0] LCR_COMB_INIT = 8'h00;
    // Combining generator input selects
    localparam logic LCR_SEL_LUT = 1'h0;
    localparam logic LCR_SEL_PIN = 1'h1;
    // Storage element source selects
    typedef enum logic [1:0] {
        LCR_SRC_FIRST,
        LCR_SRC_SECOND,
        LCR_SRC_COMB,
        LCR_SRC_BYPASS
    } lcr_src_t;
    // Cell operating mode
    typedef enum logic {
        LCR_MODE_LOGIC,
        LCR_MODE_DUALRAM
    } lcr_mode_t;
    // Storage element flip-flop reset value
    localparam logic LCR_STORE_RESET = 1'h0;
endpackage : lcr_pkg

// [testbench/lcr_user_model.sv]
// Far-side user logic: shadow of the RAM and of both storage bits
`timescale 1ns/1ps
module lcr_user_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [3:0] addr,
    input wire logic [3:0] dpra,
    input wire logic d,
    output logic [3:0] exp_out
);
    // ***
    // Shadow state
    // ***
    logic [15:0] mem = 16'h0000;
    logic q;
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= d;
        end
    end
    always_ff @(posedge clk) begin
        q <= rst ? 1'h0 : d;
    end
    assign exp_out = {mem[addr], mem[dpra], q, q};
endmodule : lcr_user_model

// [testbench/test_lcr_logic_cell.sv]
// Self-checking bench for the logic cell in dual-port RAM mode
`timescale 1ns/1ps
module test_lcr_logic_cell;
    import lcr_pkg::*;
    // ***
    // Stimulus and checking
    // ***
    logic CLK = 1'h0;
    logic RESET = 1'h1;
    logic WRITE_EN = 1'h0;
    logic BYPASS_IN = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [3:0] dpra = 4'h0;
    logic [4:0] misc = 5'h00;
    logic X, Y, XQ, YQ;
    logic [3:0] exp_out;
    logic [3:0] exp_q[$];
    logic [15:0] seed = 16'h3DFD;
    int n_errors = 0;
    int cmp_count = 0;
    int i;
    always #4 CLK = ~CLK;
    lcr_logic_cell u_lcr_logic_cell (.CLK(CLK), .RESET(RESET),
        .MODE(LCR_MODE_DUALRAM), .SEL_ALT_A(misc[0]), .SEL_ALT_B(misc[1]),
        .SEL_X_COMB(1'h0), .SEL_Y_COMB(1'h0), .SRC_UPPER(LCR_SRC_BYPASS),
        .SRC_LOWER(LCR_SRC_BYPASS), .LATCH_UPPER(1'h0), .LATCH_LOWER(1'h0),
        .LUT_LOAD(1'h0), .FIRST_LUT_INPUTS(addr), .SECOND_LUT_INPUTS(dpra),
        .COMBINE_DIRECT_IN(misc[2]), .COMBINE_ALT_IN_A(misc[3]),
        .COMBINE_ALT_IN_B(misc[4]), .BYPASS_IN(BYPASS_IN),
        .WRITE_EN(WRITE_EN), .X(X), .Y(Y), .XQ(XQ), .YQ(YQ));
    lcr_user_model u_lcr_user_model (.clk(CLK), .rst(RESET), .we(WRITE_EN),
        .addr(addr), .dpra(dpra), .d(BYPASS_IN), .exp_out(exp_out));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic compare(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t outputs %b expected %b", $time, got, exp);
        end
    endtask : compare
    task automatic step(input logic rst, input logic we,
                        input logic [3:0] a, input logic [3:0] b,
                        input logic d);
        @(posedge CLK);
        RESET <= rst;
        WRITE_EN <= we;
        addr <= a;
        dpra <= b;
        BYPASS_IN <= d;
        misc <= seed[15:11];
        #1;
        exp_q.push_back(exp_out);
    endtask : step
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // Oldest note against the settled outputs of the same cycle
    always @(negedge CLK) begin
        if (exp_q.size() > 0) begin
            compare({X, Y, XQ, YQ}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (12) step(1'h1, 1'h0, 4'h0, 4'h0, 1'h0);
        for (i = 0; i < 16; i++) begin
            step(1'h0, 1'h0, i[3:0], 4'hF - i[3:0], i[0]);
        end
        $display("test zero contents done");
        for (i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            step(1'h0, seed[0], seed[4:1], seed[10] ? seed[4:1] : seed[8:5],
                 seed[9]);
        end
        $display("test random traffic done");
        for (i = 0; i < 18; i++) begin
            step(i < 2, 1'h0, i[3:0], 4'hF - i[3:0], seed[i[3:0]]);
        end
        $display("test reset keeps contents done");
        conclude();
    end
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
endmodule : test_lcr_logic_cell
